// file: common/irq_ctl_cfg.svh
`ifndef IRQ_CTL_CFG_SVH
`define IRQ_CTL_CFG_SVH
// Register indices (printed offset 0x81 is not a multiple of four: byte address is index * 4)
`define IDX_OPTION 8'h81
`define IDX_CONTROL 8'h0B
`define IDX_PFLAG 8'h0C
`define IDX_PENABLE 8'h8C
`define IDX_STATUS 8'h03
`define IDX_CORE 8'h40
`define IDX_TIMER 8'h01
// Field positions
`define B_GIE 7
`define B_PERIPH_GROUP_ENABLE 6
`define B_T0IE 5
`define B_EXT_IRQ_ENABLE 4
`define B_PORT_CHANGE_ENABLE 3
`define B_T0IF 2
`define B_EXT_IRQ_FLAG 1
`define B_PORT_CHANGE_FLAG 0
`define B_EDGE 6
`define B_TO 4
`define B_PD 3
// Reset values
`define RST_OPTION 8'hFF
`define RST_CONTROL 8'h00
`define RST_ZERO 8'h00
`define RST_STATUS 8'h18
`define VECTOR_ADDR 13'h0004
`define TIMER_MAX 8'hFF
`define SYNC_W 2
`endif

// file: common/irq_ctl_pkg.sv
package irq_ctl_pkg;
  typedef enum logic [1:0] {
    st_run = 2'b00,
    st_sleep = 2'b01,
    st_wake = 2'b11
  } core_state_t;

  typedef struct packed {
    logic sleep_req;
    logic return_from_handler_req;
    logic ack;
    logic [12:0] pc_next;
  } core_req_t;

  typedef struct packed {
    logic vector_now;
    logic [12:0] pc_load;
    logic pc_load_en;
    logic stack_push;
    logic [12:0] stack_data;
    logic awake;
  } core_resp_t;

  typedef struct packed {
    core_state_t st;
    logic [7:0] option_config;
    logic [7:0] interrupt_control;
    logic [7:0] periph_flag_reg;
    logic [7:0] periph_enable_reg;
    logic [7:0] status;
    logic [7:0] eight_bit_timer;
    logic [1:0] ext_sync;
    logic ext_last;
    logic [7:0] port_sync0;
    logic [7:0] port_sync1;
    logic [3:0] port_last;
    logic [12:0] ret_stack;
    logic pending_vec;
    logic [31:0] prdata;
    logic pslverr;
    logic ack_wait;
    core_resp_t resp;
  } ic_state_t;
endpackage : irq_ctl_pkg

// file: hdl/mcu_interrupt_control.sv
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "irq_ctl_cfg.svh"
module mcu_interrupt_control
  import irq_ctl_pkg::*;
#(
  parameter int NUM_PERIPH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_irq_pin,
  input wire logic [7:4] upper_nibble_port,
  input wire logic timer_tick,
  input wire logic [NUM_PERIPH-1:0] periph_event,
  input wire core_req_t core_req,
  output core_resp_t core_resp,
  output logic [7:0] status_out
);
  ic_state_t s;
  ic_state_t next_s;

  function automatic logic [11:0] baddr(input logic [7:0] idx);
    baddr = {2'b00, idx, 2'b00};
  endfunction : baddr

  logic wr_en;
  logic rd_en;
  logic ext_edge;
  logic port_chg;
  logic timer_wrap;
  logic core_pending;
  logic periph_pending;
  logic any_pending;
  logic [7:0] ctl_set;
  logic [7:0] pf_set;

  // One wait state: read data and error are registered on the first access edge,
  // and a write lands on the second, the edge at which pready is high
  assign wr_en = psel && penable && pwrite && s.ack_wait;
  assign rd_en = psel && penable && !pwrite && !s.ack_wait;
  assign pready = s.ack_wait;
  assign prdata = s.prdata;
  assign pslverr = s.pslverr;
  assign core_resp = s.resp;
  assign status_out = s.status;

  // Edge and change detect read only second synchroniser stage
  // Two sync stages, detect and flag set give a fixed pin-to-request latency
  assign ext_edge = s.option_config[`B_EDGE] ? (s.ext_sync[1] && !s.ext_last)
                                              : (!s.ext_sync[1] && s.ext_last);
  assign port_chg = (s.port_sync1[7:4] != s.port_last);
  assign timer_wrap = timer_tick && (s.eight_bit_timer == `TIMER_MAX);

  assign core_pending =
    (s.interrupt_control[`B_EXT_IRQ_ENABLE] && s.interrupt_control[`B_EXT_IRQ_FLAG]) ||
    (s.interrupt_control[`B_T0IE] && s.interrupt_control[`B_T0IF]) ||
    (s.interrupt_control[`B_PORT_CHANGE_ENABLE] && s.interrupt_control[`B_PORT_CHANGE_FLAG]);
  assign periph_pending = s.interrupt_control[`B_PERIPH_GROUP_ENABLE] &&
    |(s.periph_flag_reg & s.periph_enable_reg);
  assign any_pending = core_pending || periph_pending;

  always_comb begin
    next_s = s;
    next_s.resp.vector_now = 1'b0;
    next_s.resp.pc_load_en = 1'b0;
    next_s.resp.stack_push = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.ack_wait = psel && penable && !s.ack_wait;
    ctl_set = 8'h00;
    pf_set = 8'h00;
    ctl_set[`B_EXT_IRQ_FLAG] = ext_edge;
    ctl_set[`B_PORT_CHANGE_FLAG] = port_chg;
    ctl_set[`B_T0IF] = timer_wrap;
    pf_set = 8'(periph_event);
    next_s.ext_sync = {s.ext_sync[0], ext_irq_pin};
    next_s.ext_last = s.ext_sync[1];
    next_s.port_sync0 = {upper_nibble_port, 4'h0};
    next_s.port_sync1 = s.port_sync0;
    next_s.port_last = s.port_sync1[7:4];
    if (timer_tick) begin
      next_s.eight_bit_timer = s.eight_bit_timer + 8'h01;
    end
    // Register writes; hardware set wins over software clear
    if (wr_en) begin
      case (paddr)
        baddr(`IDX_OPTION): next_s.option_config = pwdata[7:0];
        baddr(`IDX_CONTROL): next_s.interrupt_control = pwdata[7:0];
        baddr(`IDX_PFLAG): next_s.periph_flag_reg = pwdata[7:0];
        baddr(`IDX_PENABLE): next_s.periph_enable_reg = pwdata[7:0];
        baddr(`IDX_TIMER): next_s.eight_bit_timer = pwdata[7:0];
        baddr(`IDX_STATUS): next_s.status = pwdata[7:0];
        default: ;
      endcase
    end
    // Write error flagged early so it stands at the completing edge
    if (psel && penable && pwrite && !s.ack_wait) begin
      case (paddr)
        baddr(`IDX_OPTION): ;
        baddr(`IDX_CONTROL): ;
        baddr(`IDX_PFLAG): ;
        baddr(`IDX_PENABLE): ;
        baddr(`IDX_TIMER): ;
        baddr(`IDX_STATUS): ;
        default: next_s.pslverr = 1'b1;
      endcase
    end
    if (rd_en) begin
      case (paddr)
        baddr(`IDX_OPTION): next_s.prdata = {24'h0000_00, s.option_config};
        baddr(`IDX_CONTROL): next_s.prdata = {24'h0000_00, s.interrupt_control};
        baddr(`IDX_PFLAG): next_s.prdata = {24'h0000_00, s.periph_flag_reg};
        baddr(`IDX_PENABLE): next_s.prdata = {24'h0000_00, s.periph_enable_reg};
        baddr(`IDX_TIMER): next_s.prdata = {24'h0000_00, s.eight_bit_timer};
        baddr(`IDX_STATUS): next_s.prdata = {24'h0000_00, s.status};
        baddr(`IDX_CORE): next_s.prdata = {17'h0_0000, s.st, s.ret_stack};
        default: begin
          next_s.prdata = 32'h0000_0000;
          next_s.pslverr = 1'b1;
        end
      endcase
    end
    next_s.interrupt_control = next_s.interrupt_control | ctl_set;
    next_s.periph_flag_reg = next_s.periph_flag_reg | pf_set;
    case (s.st)
      st_run: begin
        if (core_req.return_from_handler_req) begin
          next_s.resp.pc_load = s.ret_stack;
          next_s.resp.pc_load_en = 1'b1;
          next_s.interrupt_control[`B_GIE] = 1'b1;
        end else if (s.interrupt_control[`B_GIE] && any_pending) begin
          // Only the return PC is saved
          next_s.ret_stack = core_req.pc_next;
          next_s.resp.stack_push = 1'b1;
          next_s.resp.stack_data = core_req.pc_next;
          next_s.resp.pc_load = `VECTOR_ADDR;
          next_s.resp.pc_load_en = 1'b1;
          next_s.resp.vector_now = 1'b1;
          next_s.interrupt_control[`B_GIE] = 1'b0;
        end else if (core_req.sleep_req) begin
          if (!any_pending) begin
            next_s.st = st_sleep;
            next_s.resp.awake = 1'b0;
            next_s.status[`B_TO] = 1'b1;
            next_s.status[`B_PD] = 1'b0;
          end // Pending: sleep acts as no-op
        end
      end
      st_sleep: begin
        if (any_pending) begin
          next_s.st = st_wake;
          next_s.resp.awake = 1'b1;
          next_s.status[`B_TO] = 1'b1;
          next_s.status[`B_PD] = 1'b0;
        end
      end
      st_wake: begin
        next_s.st = st_run;
        // Resume at PC plus one; GLOBAL_IRQ_ENABLE set then vectors
        next_s.resp.pc_load = core_req.pc_next;
        next_s.resp.pc_load_en = !s.interrupt_control[`B_GIE];
        next_s.pending_vec = s.interrupt_control[`B_GIE];
      end
      default: next_s.st = st_run;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.st <= st_run;
      s.option_config <= `RST_OPTION;
      s.interrupt_control <= `RST_CONTROL;
      s.periph_flag_reg <= `RST_ZERO;
      s.periph_enable_reg <= `RST_ZERO;
      s.status <= `RST_STATUS;
      s.resp.awake <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Latency check: pending enabled request with GLOBAL_IRQ_ENABLE set vectors next edge
  a_vector_latency: assert property (@(posedge pclk) disable iff (!presetn)
    (s.st == st_run && !core_req.return_from_handler_req && s.interrupt_control[`B_GIE] && any_pending)
    |=> (s.resp.vector_now && s.resp.pc_load == `VECTOR_ADDR))
    else $error("vector not taken");
  a_gie_cleared: assert property (@(posedge pclk) disable iff (!presetn)
    s.resp.vector_now |-> !s.interrupt_control[`B_GIE])
    else $error("global enable not cleared on entry");
  a_return_from_handler_sets: assert property (@(posedge pclk) disable iff (!presetn)
    (s.st == st_run && core_req.return_from_handler_req) |=> s.interrupt_control[`B_GIE])
    else $error("return did not set global enable");
  a_ext_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    ext_edge |=> s.interrupt_control[`B_EXT_IRQ_FLAG])
    else $error("external flag missed");
  a_timer_flag: assert property (@(posedge pclk) disable iff (!presetn)
    timer_wrap |=> (s.interrupt_control[`B_T0IF] && s.eight_bit_timer == 8'h00))
    else $error("timer wrap flag missed");
  a_port_flag: assert property (@(posedge pclk) disable iff (!presetn)
    port_chg |=> s.interrupt_control[`B_PORT_CHANGE_FLAG])
    else $error("port change flag missed");
  a_wake_status: assert property (@(posedge pclk) disable iff (!presetn)
    (s.st == st_sleep && any_pending) |=> (s.st == st_wake && s.status[`B_TO]
      && !s.status[`B_PD]))
    else $error("wake status wrong");
  a_sleep_noop: assert property (@(posedge pclk) disable iff (!presetn)
    (s.st == st_run && core_req.sleep_req && any_pending && !core_req.return_from_handler_req)
    |=> (s.st == st_run && $stable(s.status)))
    else $error("sleep not a no-op");
  a_periph_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (|periph_event) |=> ((s.periph_flag_reg[NUM_PERIPH-1:0] & $past(periph_event))
      == $past(periph_event)))
    else $error("peripheral flag missed");
  a_apb_wait_one: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready)
    else $error("access not completed after one wait state");
  a_group_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (s.st == st_run && !core_pending && !s.interrupt_control[`B_PERIPH_GROUP_ENABLE])
    |=> !s.resp.vector_now)
    else $error("peripheral request passed a closed group enable");
endmodule : mcu_interrupt_control

// file: tb/core_model.sv
`timescale 1ns/1ps
module core_model
  import irq_ctl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire core_resp_t core_resp,
  output core_req_t core_req
);
  // Fetch unit parked at one address so the return address is known
  initial core_req = '{sleep_req: 1'b0, return_from_handler_req: 1'b0, ack: 1'b0, pc_next: 13'h0123};

  // One-cycle sleep or return strobe, launched and released after an edge
  task pulse(input logic sleep);
    @(posedge pclk);
    core_req.sleep_req <= sleep;
    core_req.return_from_handler_req <= ~sleep;
    @(posedge pclk);
    core_req.sleep_req <= 1'b0;
    core_req.return_from_handler_req <= 1'b0;
  endtask : pulse
endmodule : core_model

// file: tb/tb.sv
`timescale 1ns/1ps
`include "irq_ctl_cfg.svh"
module tb
  import irq_ctl_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic ext_irq_pin = 0, timer_tick = 0, pready, pslverr, err;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [7:4] upper_nibble_port = '0;
  logic [7:0] periph_event = '0, status_out;
  core_req_t core_req;
  core_resp_t core_resp;
  int miscompares = 0, n_checks = 0;
  localparam logic [11:0] A_OPT = 12'h204, A_CTL = 12'h02C, A_PF = 12'h030, A_PE = 12'h230;

  always #20 pclk = ~pclk;

  mcu_interrupt_control mcu_interrupt_control_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_irq_pin(ext_irq_pin),
    .upper_nibble_port(upper_nibble_port), .timer_tick(timer_tick), .periph_event(periph_event),
    .core_req(core_req), .core_resp(core_resp), .status_out(status_out));
  core_model core_model_i (.pclk(pclk), .presetn(presetn), .core_resp(core_resp),
    .core_req(core_req));

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
  endtask : rchk

  task wait_load(input string what, input logic [12:0] exp);
    for (int i = 0; i < 40 && core_resp.pc_load_en !== 1'b1; i++) @(negedge pclk);
    chk({what, " strobe"}, 32'h0000_0001, {31'h0, core_resp.pc_load_en});
    chk(what, {19'h0, exp}, {19'h0, core_resp.pc_load});
  endtask : wait_load

  task t_reset;
    rchk("option", A_OPT, 32'h0000_00FF);
    rchk("control", A_CTL, 32'h0000_0000);
    rchk("status", 12'h00C, 32'h0000_0018);
    apb(1'b0, 12'h3FC, 32'h0000_0000);
    chk("unmapped err", 32'h0000_0001, {31'h0, err});
    chk("unmapped data", 32'h0000_0000, rd);
    $display("test reset done");
  endtask : t_reset

  task t_flags;
    @(posedge pclk);
    ext_irq_pin <= 1'b1;
    upper_nibble_port[5] <= 1'b1;
    periph_event[3] <= 1'b1;
    @(posedge pclk);
    periph_event[3] <= 1'b0;
    repeat (256) begin
      @(posedge pclk);
      timer_tick <= 1'b1;
    end
    @(posedge pclk);
    timer_tick <= 1'b0;
    rchk("flags with enables off", A_CTL, 32'h0000_0007);
    rchk("periph flag", A_PF, 32'h0000_0008);
    apb(1'b1, A_OPT, 32'h0000_00BF);
    apb(1'b1, A_CTL, 32'h0000_0000);
    @(posedge pclk);
    ext_irq_pin <= 1'b0;
    repeat (8) @(posedge pclk);
    rchk("falling edge flag", A_CTL, 32'h0000_0002);
    $display("test flags done");
  endtask : t_flags

  task t_vector;
    apb(1'b1, A_PE, 32'h0000_0008);
    apb(1'b1, A_CTL, 32'h0000_00C0);
    wait_load("vector", 13'h0004);
    chk("pushed pc", 32'h0000_0123, {19'h0, core_resp.stack_data});
    rchk("enable cleared", A_CTL, 32'h0000_0040);
    apb(1'b1, A_PF, 32'h0000_0000);
    core_model_i.pulse(1'b0);
    wait_load("return", 13'h0123);
    rchk("enable restored", A_CTL, 32'h0000_00C0);
    $display("test vector done");
  endtask : t_vector

  task t_sleep;
    apb(1'b1, A_CTL, 32'h0000_0010);
    core_model_i.pulse(1'b1);
    repeat (3) @(posedge pclk);
    chk("sleep status", 32'h0000_0010, {24'h0, status_out});
    chk("asleep", 32'h0000_0000, {31'h0, core_resp.awake});
    ext_irq_pin <= 1'b1;
    @(posedge pclk);
    ext_irq_pin <= 1'b0;
    wait_load("wake resume", 13'h0123);
    chk("awake", 32'h0000_0001, {31'h0, core_resp.awake});
    rchk("wake control", A_CTL, 32'h0000_0012);
    core_model_i.pulse(1'b1);
    repeat (3) @(posedge pclk);
    chk("sleep as no-op", 32'h0000_0001, {31'h0, core_resp.awake});
    chk("no-op status", 32'h0000_0010, {24'h0, status_out});
    $display("test sleep done");
  endtask : t_sleep

  task summarize;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_flags();
    t_vector();
    t_sleep();
    summarize();
  end

  initial begin
    #200000;
    miscompares++;
    summarize();
  end
endmodule : tb
